/* common/mif_map.svh */
`ifndef MIF_MAP_SVH
`define MIF_MAP_SVH

// ****************************************
// Register offsets
// ****************************************
`define MIF_ADDR_W        4
`define MIF_REG_FLAG      4'h0
`define MIF_REG_EN        4'h1
`define MIF_REG_GLOBAL    4'h2
`define MIF_REG_PA_SEL    4'h3
`define MIF_REG_PB_SEL    4'h4
`define MIF_REG_EXT_CFG   4'h5
`define MIF_REG_OSC_CMP   4'h6
`define MIF_REG_STATUS    4'h7

// ****************************************
// Field positions and widths
// ****************************************
`define MIF_NSRC          12
`define MIF_T0            0
`define MIF_T1            1
`define MIF_T5            5
`define MIF_WDT           6
`define MIF_PORT          7
`define MIF_EXT0          8
`define MIF_EXT1          9
`define MIF_LVD           10
`define MIF_CMP           11
`define MIF_EXT0_SEL      0
`define MIF_EXT1_SEL      1
`define MIF_EDGE_POL      2
`define MIF_PA_W          8
`define MIF_PB_W          6
`define MIF_CMP_OUT_BIT   7
`define MIF_PRIME_W       3
`define MIF_RESET_ZERO    16'h0000

`endif

/* common/mif_pkg.sv */
package mif_pkg;
    typedef logic [15:0] mif_word_t;
    typedef enum logic [1:0] {
        MIF_SEQ_RUN,
        MIF_SEQ_HW,
        MIF_SEQ_SW
    } mif_seq_t;
endpackage

/* rtl/mif_sync.sv */
`timescale 1ns/1ns
`include "mif_map.svh"
module mif_sync
    import mif_pkg::*;
#(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         core_clk,
    input  wire logic         rst_n,
    input  wire logic         clk_en,
    // Data
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] sync_q;
    logic [W-1:0] sync_d;

    always_comb begin
        meta_d = clk_en ? async_in : meta_q;
        sync_d = clk_en ? meta_q : sync_q;
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_out = sync_q;
endmodule

/* rtl/mif_edge.sv */
`timescale 1ns/1ns
`include "mif_map.svh"
module mif_edge
    import mif_pkg::*;
#(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         core_clk,
    input  wire logic         rst_n,
    input  wire logic         clk_en,
    // Synchronised level and its history
    input  wire logic [W-1:0] level_in,
    output logic      [W-1:0] level_prev,
    output logic      [W-1:0] changed,
    output logic      [W-1:0] rose,
    output logic      [W-1:0] fell
);
    logic [W-1:0]            prev_q;
    logic [W-1:0]            prev_d;
    logic [`MIF_PRIME_W-1:0] prime_q;
    logic [`MIF_PRIME_W-1:0] prime_d;

    // The synchroniser ahead still shows its reset value for two edges, so the
    // first samples after reset only prime the history. A pin that sits high at
    // reset release is then not taken for a rising edge.
    always_comb begin
        prev_d  = clk_en ? level_in : prev_q;
        prime_d = clk_en ? {prime_q[`MIF_PRIME_W-2:0], 1'b1} : prime_q;
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_q  <= '0;
            prime_q <= '0;
        end else begin
            prev_q  <= prev_d;
            prime_q <= prime_d;
        end
    end

    assign level_prev = prev_q;
    assign changed    = prime_q[`MIF_PRIME_W-1] ? (level_in ^ prev_q) : '0;
    assign rose       = changed & level_in;
    assign fell       = changed & prev_q;
endmodule

/* rtl/mif_irq_flags.sv */
`timescale 1ns/1ns
`include "mif_map.svh"

// How it works
// RULE_01 - Timer zero wrap sets its flag; requests when its enable and global are set.
// RULE_02 - Timer one underflow sets its flag; requests with its enable and global.
// RULE_03 - Timer two underflow sets its flag; requests with its enable and global.
// RULE_04 - Timer three underflow sets its flag; requests with its enable and global.
// RULE_05 - Timer four underflow sets its flag; requests with its enable and global.
// RULE_06 - Timer five underflow sets its flag; requests with its enable and global.
// RULE_07 - Watchdog expiry in interrupt mode sets watchdog flag; gated by enables.
// RULE_08 - Selected input pin level change on port A or B sets port-change flag.
// RULE_09 - External select on port B pin 0 or 1 masks that pin's change detect.
// RULE_10 - External zero select plus chosen edge on pin zero sets external-zero flag.
// RULE_11 - External one select plus chosen edge on pin one sets external-one flag.
// RULE_12 - Falling low-voltage indication sets low-voltage flag; gated by enables.
// RULE_13 - Live comparator output differing from its registered copy sets comparator flag.
// RULE_14 - Reading oscillator/comparator control register refreshes registered comparator copy.
// RULE_15 - Flags stay set until firmware writes zero to the flag bit.
// RULE_16 - Accepted hardware request vectors to hardware entry and clears global enable.
// RULE_17 - Software interrupt vectors to software entry and clears global enable always.
// RULE_18 - Return-from-interrupt sets global enable and resumes the interrupted code.
// RULE_19 - An event in the same cycle as a clearing write keeps the flag set.
// RULE_20 - Request is OR of flag AND enable over sources, qualified by global enable.
module mif_irq_flags
    import mif_pkg::*;
(
    // Clock and reset
    input  wire logic                   core_clk,
    input  wire logic                   rst_n,
    input  wire logic                   clk_en,
    // Register port
    input  wire logic [`MIF_ADDR_W-1:0] reg_addr,
    input  wire logic [15:0]            reg_wdata,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    output logic      [15:0]            reg_rdata,
    // Event pulses from same-clock timers and watchdog
    input  wire logic                   tmr_zero_wrap,
    input  wire logic [4:0]             tmr_underflow,
    input  wire logic                   watchdog_expire,
    input  wire logic                   watchdog_irq_mode,
    // Pins and analog indications from outside the clock domain
    input  wire logic [`MIF_PA_W-1:0]   porta_pin,
    input  wire logic [`MIF_PB_W-1:0]   portb_pin,
    input  wire logic [`MIF_PA_W-1:0]   porta_is_input,
    input  wire logic [`MIF_PB_W-1:0]   portb_is_input,
    input  wire logic                   low_voltage_ok,
    input  wire logic                   comparator_out,
    // CPU core sequencer
    input  wire logic                   irq_accept,
    input  wire logic                   soft_irq_op,
    input  wire logic                   return_from_irq_op,
    input  wire logic                   enable_irq_op,
    input  wire logic                   disable_irq_op,
    output logic                        hw_irq_req,
    output logic                        vector_hw,
    output logic                        vector_sw,
    output logic                        global_irq_enable
);
    // ****************************************
    // Input synchronisers and edge history
    // ****************************************
    localparam int NPIN = `MIF_PA_W + `MIF_PB_W + 2;

    logic [NPIN-1:0] pin_sync;
    logic [NPIN-1:0] pin_chg;
    logic [NPIN-1:0] pin_rise;
    logic [NPIN-1:0] pin_fall;

    mif_sync #(.W(NPIN)) u_sync (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .clk_en   (clk_en),
        .async_in ({comparator_out, low_voltage_ok, portb_pin, porta_pin}),
        .sync_out (pin_sync)
    );

    mif_edge #(.W(NPIN)) u_edge (
        .core_clk   (core_clk),
        .rst_n      (rst_n),
        .clk_en     (clk_en),
        .level_in   (pin_sync),
        .level_prev (),
        .changed    (pin_chg),
        .rose       (pin_rise),
        .fell       (pin_fall)
    );

    logic [`MIF_PA_W-1:0] pa_chg;
    logic [`MIF_PB_W-1:0] pb_chg;
    logic [`MIF_PB_W-1:0] pb_rise;
    logic [`MIF_PB_W-1:0] pb_fall;
    logic                 lvd_fall;
    logic                 cmp_live;

    assign pa_chg   = pin_chg[`MIF_PA_W-1:0];
    assign pb_chg   = pin_chg[`MIF_PA_W +: `MIF_PB_W];
    assign pb_rise  = pin_rise[`MIF_PA_W +: `MIF_PB_W];
    assign pb_fall  = pin_fall[`MIF_PA_W +: `MIF_PB_W];
    assign lvd_fall = pin_fall[NPIN-2];
    assign cmp_live = pin_sync[NPIN-1];

    // ****************************************
    // Register decode
    // ****************************************
    function automatic logic hit(input logic [`MIF_ADDR_W-1:0] a,
                                 input logic [`MIF_ADDR_W-1:0] r);
        return a == r;
    endfunction

    logic [`MIF_NSRC-1:0] flag_q,  flag_d;
    logic [`MIF_NSRC-1:0] en_q,    en_d;
    logic [`MIF_PA_W-1:0] pa_sel_q, pa_sel_d;
    logic [`MIF_PB_W-1:0] pb_sel_q, pb_sel_d;
    logic [2:0]           ext_q,   ext_d;
    logic                 gie_q,   gie_d;
    logic                 cmp_reg_q, cmp_reg_d;
    logic [15:0]          rdata_q, rdata_d;
    logic                 req_q,   req_d;
    logic                 vhw_q,   vhw_d;
    logic                 vsw_q,   vsw_d;

    // ****************************************
    // Event collection
    // ****************************************
    logic [`MIF_NSRC-1:0] evt;
    logic [`MIF_PB_W-1:0] pb_mask;
    logic [1:0]           ext_edge;

    generate
        for (genvar i = 0; i < 2; i++) begin : g_ext
            // Polarity bit set selects rising edges, clear selects falling.
            assign ext_edge[i] = ext_q[i] &
                (ext_q[`MIF_EDGE_POL] ? pb_rise[i] : pb_fall[i]); // RULE_10 RULE_11
        end
    endgenerate

    always_comb begin
        pb_mask = pb_sel_q & portb_is_input;
        pb_mask[0] = pb_mask[0] & ~ext_q[`MIF_EXT0_SEL]; // RULE_09
        pb_mask[1] = pb_mask[1] & ~ext_q[`MIF_EXT1_SEL]; // RULE_09
        evt = '0;
        evt[`MIF_T0] = tmr_zero_wrap; // RULE_01
        evt[`MIF_T5:`MIF_T1] = tmr_underflow; // RULE_02 RULE_03 RULE_04 RULE_05 RULE_06
        evt[`MIF_WDT] = watchdog_expire & watchdog_irq_mode; // RULE_07
        evt[`MIF_PORT] = |(pa_chg & pa_sel_q & porta_is_input) |
                         |(pb_chg & pb_mask); // RULE_08
        evt[`MIF_EXT0] = ext_edge[0]; // RULE_10
        evt[`MIF_EXT1] = ext_edge[1]; // RULE_11
        evt[`MIF_LVD] = lvd_fall; // RULE_12
        evt[`MIF_CMP] = cmp_live ^ cmp_reg_q; // RULE_13
    end

    // ****************************************
    // Registers and flags
    // ****************************************
    logic wr_flag;
    logic pending;

    assign wr_flag = reg_wr & hit(reg_addr, `MIF_REG_FLAG);
    assign pending = |(flag_q & en_q);

    always_comb begin
        flag_d    = flag_q;
        en_d      = en_q;
        pa_sel_d  = pa_sel_q;
        pb_sel_d  = pb_sel_q;
        ext_d     = ext_q;
        gie_d     = gie_q;
        cmp_reg_d = cmp_reg_q;
        rdata_d   = rdata_q;
        vhw_d     = vhw_q;
        vsw_d     = vsw_q;
        if (clk_en) begin
            vhw_d   = 1'b0;
            vsw_d   = 1'b0;
            rdata_d = `MIF_RESET_ZERO;
            // Writing zero clears a bit; writing one leaves it alone.
            if (wr_flag) begin
                flag_d = flag_q & reg_wdata[`MIF_NSRC-1:0]; // RULE_15
            end
            flag_d = flag_d | evt; // RULE_19
            if (reg_wr) begin
                if (hit(reg_addr, `MIF_REG_EN)) begin
                    en_d = reg_wdata[`MIF_NSRC-1:0];
                end
                if (hit(reg_addr, `MIF_REG_PA_SEL)) begin
                    pa_sel_d = reg_wdata[`MIF_PA_W-1:0];
                end
                if (hit(reg_addr, `MIF_REG_PB_SEL)) begin
                    pb_sel_d = reg_wdata[`MIF_PB_W-1:0];
                end
                if (hit(reg_addr, `MIF_REG_EXT_CFG)) begin
                    ext_d = reg_wdata[2:0];
                end
                if (hit(reg_addr, `MIF_REG_GLOBAL)) begin
                    gie_d = reg_wdata[0];
                end
            end
            if (reg_rd) begin
                unique case (reg_addr)
                    `MIF_REG_FLAG:    rdata_d = {4'h0, flag_q};
                    `MIF_REG_EN:      rdata_d = {4'h0, en_q};
                    `MIF_REG_GLOBAL:  rdata_d = {15'h0000, gie_q};
                    `MIF_REG_PA_SEL:  rdata_d = {8'h00, pa_sel_q};
                    `MIF_REG_PB_SEL:  rdata_d = {10'h000, pb_sel_q};
                    `MIF_REG_EXT_CFG: rdata_d = {13'h0000, ext_q};
                    `MIF_REG_OSC_CMP: begin
                        rdata_d[`MIF_CMP_OUT_BIT] = cmp_live;
                        cmp_reg_d = cmp_live; // RULE_14
                    end
                    `MIF_REG_STATUS:  rdata_d = {14'h0000, pending, req_q};
                    default:          rdata_d = `MIF_RESET_ZERO;
                endcase
            end
            // Sequencer ops take priority over a register write to the enable.
            if (enable_irq_op) begin
                gie_d = 1'b1;
            end
            if (disable_irq_op) begin
                gie_d = 1'b0;
            end
            if (return_from_irq_op) begin
                gie_d = 1'b1; // RULE_18
            end
            if (soft_irq_op) begin
                gie_d = 1'b0; // RULE_17
                vsw_d = 1'b1; // RULE_17
            end else if (irq_accept && req_q) begin
                gie_d = 1'b0; // RULE_16
                vhw_d = 1'b1; // RULE_16
            end
        end
    end

    // Request is formed from the next flags, so it changes with the flags and the output is a clean flop.
    assign req_d = clk_en ? (gie_d & |(flag_d & en_d)) : req_q; // RULE_20

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            flag_q    <= '0;
            en_q      <= '0;
            pa_sel_q  <= '0;
            pb_sel_q  <= '0;
            ext_q     <= '0;
            gie_q     <= 1'b0;
            cmp_reg_q <= 1'b0;
            rdata_q   <= '0;
            req_q     <= 1'b0;
            vhw_q     <= 1'b0;
            vsw_q     <= 1'b0;
        end else begin
            flag_q    <= flag_d;
            en_q      <= en_d;
            pa_sel_q  <= pa_sel_d;
            pb_sel_q  <= pb_sel_d;
            ext_q     <= ext_d;
            gie_q     <= gie_d;
            cmp_reg_q <= cmp_reg_d;
            rdata_q   <= rdata_d;
            req_q     <= req_d;
            vhw_q     <= vhw_d;
            vsw_q     <= vsw_d;
        end
    end

    assign reg_rdata         = rdata_q;
    assign hw_irq_req        = req_q;
    assign vector_hw         = vhw_q;
    assign vector_sw         = vsw_q;
    assign global_irq_enable = gie_q;
endmodule

/* tb/mif_irq_flags_properties.sv */
`timescale 1ns/1ns
`include "mif_map.svh"
module mif_irq_checker (
    // Clock and reset
    input wire logic                   core_clk,
    input wire logic                   rst_n,
    input wire logic                   clk_en,
    // Register port
    input wire logic [`MIF_ADDR_W-1:0] reg_addr,
    input wire logic                   reg_rd,
    input wire logic [15:0]            reg_rdata,
    // Sequencer side
    input wire logic                   irq_accept,
    input wire logic                   soft_irq_op,
    input wire logic                   return_from_irq_op,
    input wire logic                   hw_irq_req,
    input wire logic                   vector_hw,
    input wire logic                   vector_sw,
    input wire logic                   global_irq_enable
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    soft_vector_a: assert property (clk_en && soft_irq_op |=> vector_sw && !global_irq_enable)
        else $error("software op gave no vector or left global enable set");
    sw_cause_a: assert property (vector_sw |-> $past(soft_irq_op))
        else $error("software vector without a software op");
    accept_vector_a: assert property (clk_en && irq_accept && hw_irq_req && !soft_irq_op
        |=> vector_hw && !global_irq_enable && !hw_irq_req)
        else $error("accepted request did not vector and mask");
    hw_cause_a: assert property (vector_hw |-> $past(irq_accept) && $past(hw_irq_req))
        else $error("hardware vector without an accepted request");
    vector_once_a: assert property (vector_hw && clk_en |=> !vector_hw)
        else $error("hardware vector longer than one cycle");
    return_sets_a: assert property (clk_en && return_from_irq_op && !soft_irq_op
        && !irq_accept |=> global_irq_enable)
        else $error("return op did not set global enable");
    req_gated_a: assert property (hw_irq_req |-> global_irq_enable)
        else $error("request raised with global enable clear");
    status_read_a: assert property ($past(reg_rd && clk_en) && $past(reg_addr) == 4'h7
        |-> reg_rdata[0] == $past(hw_irq_req))
        else $error("status read does not show the request");
endmodule

bind mif_irq_flags mif_irq_checker chk_u (
    .core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_accept(irq_accept),
    .soft_irq_op(soft_irq_op), .return_from_irq_op(return_from_irq_op),
    .hw_irq_req(hw_irq_req), .vector_hw(vector_hw), .vector_sw(vector_sw),
    .global_irq_enable(global_irq_enable)
);

/* tb/mif_cpu_model.sv */
`timescale 1ns/1ns
module mif_cpu_model (
    // Clock and reset
    input wire logic       core_clk,
    input wire logic       rst_n,
    // Bench control
    input wire logic       auto_on,
    input wire logic [3:0] delay,
    // Request and answer
    input wire logic       hw_irq_req,
    output logic           irq_accept
);
    logic [3:0] wait_q;

    // The request must stand for delay plus one cycles first, so a slow core is modelled too.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_q     <= 4'h0;
            irq_accept <= 1'h0;
        end else begin
            irq_accept <= 1'h0;
            if (auto_on && hw_irq_req && !irq_accept) begin
                if (wait_q == delay) begin
                    irq_accept <= 1'h1;
                    wait_q     <= 4'h0;
                end else begin
                    wait_q <= wait_q + 4'h1;
                end
            end else begin
                wait_q <= 4'h0;
            end
        end
    end
endmodule

/* tb/testbench.sv */
`timescale 1ns/1ns
`include "mif_map.svh"
module testbench
    import mif_pkg::*;
;
    typedef struct packed {logic [6:0] ev; logic mode; mif_word_t exp;} mif_row_t;
    logic       core_clk = 1'h0, rst_n = 1'h0, clk_en = 1'h1;
    logic [3:0] reg_addr = 4'h0;
    mif_word_t  reg_wdata = 16'h0000, reg_rdata;
    logic       reg_wr = 1'h0, reg_rd = 1'h0, tmr_zero_wrap = 1'h0;
    logic [4:0] tmr_underflow = 5'h00;
    logic       watchdog_expire = 1'h0, watchdog_irq_mode = 1'h0;
    logic [7:0] porta_pin = 8'h00, pa_in = 8'hff;
    logic [5:0] portb_pin = 6'h02, pb_in = 6'h3f;
    logic       low_voltage_ok = 1'h1, comparator_out = 1'h0, auto_on = 1'h0;
    logic       soft_irq_op = 1'h0, return_from_irq_op = 1'h0;
    logic       enable_irq_op = 1'h0, disable_irq_op = 1'h0;
    logic       irq_accept, hw_irq_req, vector_hw, vector_sw, global_irq_enable;
    logic [3:0] acc_delay = 4'h2;
    int         n_mismatch = 0, n_compared = 0, cyc = 0, k;
    mif_row_t   rows [8] = '{'{7'h01, 1'h0, 16'h0001}, '{7'h02, 1'h0, 16'h0002},
        '{7'h04, 1'h0, 16'h0004}, '{7'h08, 1'h0, 16'h0008}, '{7'h10, 1'h0, 16'h0010},
        '{7'h20, 1'h0, 16'h0020}, '{7'h40, 1'h1, 16'h0040}, '{7'h40, 1'h0, 16'h0000}};

    always #50 core_clk = ~core_clk;

    mif_irq_flags dut_u (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .tmr_zero_wrap(tmr_zero_wrap), .tmr_underflow(tmr_underflow),
        .watchdog_expire(watchdog_expire), .watchdog_irq_mode(watchdog_irq_mode),
        .porta_pin(porta_pin), .portb_pin(portb_pin), .porta_is_input(pa_in),
        .portb_is_input(pb_in), .low_voltage_ok(low_voltage_ok),
        .comparator_out(comparator_out), .irq_accept(irq_accept), .soft_irq_op(soft_irq_op),
        .return_from_irq_op(return_from_irq_op), .enable_irq_op(enable_irq_op),
        .disable_irq_op(disable_irq_op), .hw_irq_req(hw_irq_req), .vector_hw(vector_hw),
        .vector_sw(vector_sw), .global_irq_enable(global_irq_enable));

    mif_cpu_model cpu_u (.core_clk(core_clk), .rst_n(rst_n), .auto_on(auto_on),
        .delay(acc_delay), .hw_irq_req(hw_irq_req), .irq_accept(irq_accept));

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input mif_word_t d);
        @(posedge core_clk);
        reg_wr <= 1'h1; reg_addr <= a; reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'h0;
    endtask

    // Read data stand only in the cycle after the strobe, so they are taken just after that edge.
    task automatic rd(input logic [3:0] a, input mif_word_t m, input mif_word_t e);
        @(posedge core_clk);
        reg_rd <= 1'h1; reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'h0;
        #1 check(reg_rdata & m, e);
    endtask

    // Op code bits: 8 software, 4 return, 2 enable, 1 disable.
    task automatic drv(input logic [6:0] e, input logic m, input logic [3:0] o);
        @(posedge core_clk);
        {watchdog_expire, tmr_underflow, tmr_zero_wrap} <= e;
        watchdog_irq_mode <= m;
        {soft_irq_op, return_from_irq_op, enable_irq_op, disable_irq_op} <= o;
        @(posedge core_clk);
        {watchdog_expire, tmr_underflow, tmr_zero_wrap} <= 7'h00;
        {soft_irq_op, return_from_irq_op, enable_irq_op, disable_irq_op} <= 4'h0;
    endtask

    task automatic settle_read(input mif_word_t e);
        repeat (6) @(posedge core_clk);
        rd(4'h0, 16'h0fff, e);
    endtask

    task automatic end_of_test;
        $display("Comparisons %0d, mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_mismatch++;
            end_of_test();
        end
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (10) @(posedge core_clk);
        rst_n <= 1'h1;
        rd(4'h0, 16'hffff, 16'h0000);
        rd(4'hf, 16'hffff, 16'h0000);
        wr(4'h1, 16'h0fff);
        foreach (rows[i]) begin
            drv(rows[i].ev, rows[i].mode, 4'h0);
            repeat (2) @(posedge core_clk);
            #1 check(hw_irq_req, 1'h0);
            drv(7'h00, rows[i].mode, 4'h2);
            repeat (2) @(posedge core_clk);
            #1 check(hw_irq_req, |rows[i].exp);
            rd(4'h7, 16'h0003, {14'h0000, |rows[i].exp, |rows[i].exp});
            rd(4'h0, 16'h0fff, rows[i].exp);
            drv(7'h00, rows[i].mode, 4'h1);
            wr(4'h0, 16'h0000);
        end
        drv(7'h01, 1'h1, 4'h0);
        @(posedge core_clk);
        reg_wr <= 1'h1; reg_addr <= 4'h0; reg_wdata <= 16'h0000; tmr_underflow <= 5'h01;
        @(posedge core_clk);
        reg_wr <= 1'h0; tmr_underflow <= 5'h00;
        rd(4'h0, 16'h0fff, 16'h0002);
        wr(4'h0, 16'h0000);
        wr(4'h3, 16'h0008);
        wr(4'h4, 16'h0003);
        wr(4'h5, 16'h0005);
        @(posedge core_clk) porta_pin <= 8'h08;
        settle_read(16'h0080);
        wr(4'h0, 16'h0000);
        @(posedge core_clk) portb_pin <= 6'h03;
        settle_read(16'h0100);
        wr(4'h0, 16'h0000);
        wr(4'h5, 16'h0002);
        @(posedge core_clk) portb_pin <= 6'h01;
        settle_read(16'h0200);
        wr(4'h0, 16'h0000);
        @(posedge core_clk) low_voltage_ok <= 1'h0;
        settle_read(16'h0400);
        wr(4'h0, 16'h0000);
        @(posedge core_clk) comparator_out <= 1'h1;
        settle_read(16'h0800);
        rd(4'h6, 16'h0080, 16'h0080);
        wr(4'h0, 16'h0000);
        settle_read(16'h0000);
        @(posedge core_clk) auto_on <= 1'h1;
        wr(4'h1, 16'h0001);
        drv(7'h00, 1'h1, 4'h2);
        drv(7'h01, 1'h1, 4'h0);
        for (k = 0; k < 20 && vector_hw !== 1'h1; k++) begin
            @(posedge core_clk);
            #1;
        end
        check(vector_hw, 1'h1);
        check(global_irq_enable, 1'h0);
        wr(4'h0, 16'h0000);
        drv(7'h00, 1'h1, 4'h4);
        #1 check(global_irq_enable, 1'h1);
        // With the enable low, a timer pulse and a software op are both ignored.
        @(posedge core_clk) clk_en <= 1'h0;
        drv(7'h01, 1'h1, 4'h8);
        @(posedge core_clk) clk_en <= 1'h1;
        #1 check({vector_sw, global_irq_enable}, 2'h1);
        rd(4'h0, 16'h0fff, 16'h0000);
        repeat (2) begin
            drv(7'h00, 1'h1, 4'h8);
            #1 check({vector_sw, global_irq_enable}, 2'h2);
        end
        // Reset in mid-run with a request standing, then a pin already high at release.
        drv(7'h01, 1'h1, 4'h2);
        @(posedge core_clk) rst_n <= 1'h0;
        #1 check({hw_irq_req, vector_hw, vector_sw, global_irq_enable}, 4'h0);
        check(reg_rdata, 16'h0000);
        repeat (2) @(posedge core_clk);
        rst_n <= 1'h1;
        wr(4'h5, 16'h0005);
        settle_read(16'h0800);
        end_of_test();
    end
endmodule
